/* shared/crbm_pkg.sv */
package crbm_pkg;
	localparam int ADDR_W = 12;
	localparam int BYTE_W = 8;
	localparam int PC_W = 15;
	localparam int PTR_W = 16;
	localparam int BANK_W = 5;
	localparam int SLOT_W = 7;

	// register offsets as seen in the last bank; only the low SLOT_W bits decode
	localparam logic [ADDR_W-1:0] OFF_WINDOW0 = 12'hf80;
	localparam logic [ADDR_W-1:0] OFF_WINDOW1 = 12'hf81;
	localparam logic [ADDR_W-1:0] OFF_PC_LOW = 12'hf82;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 12'hf83;
	localparam logic [ADDR_W-1:0] OFF_PTR0_LOW = 12'hf84;
	localparam logic [ADDR_W-1:0] OFF_PTR0_HIGH = 12'hf85;
	localparam logic [ADDR_W-1:0] OFF_PTR1_LOW = 12'hf86;
	localparam logic [ADDR_W-1:0] OFF_PTR1_HIGH = 12'hf87;
	localparam logic [ADDR_W-1:0] OFF_BANK_SEL = 12'hf88;
	localparam logic [ADDR_W-1:0] OFF_WORKING = 12'hf89;
	localparam logic [ADDR_W-1:0] OFF_PC_LATCH = 12'hf8a;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CTRL = 12'hf8b;
	localparam logic [ADDR_W-1:0] OFF_GROUP_LAST = 12'hf9f;

	// status field positions
	localparam int ST_TIMEOUT = 4;
	localparam int ST_POWERDOWN = 3;
	localparam int ST_ZERO = 2;
	localparam int ST_DIGIT_CARRY = 1;
	localparam int ST_CARRY = 0;

	// implemented-bit masks
	localparam logic [BYTE_W-1:0] STATUS_MASK = 8'h1f;
	localparam logic [BYTE_W-1:0] STATUS_SW_MASK = 8'h07;
	localparam logic [BYTE_W-1:0] BANK_MASK = 8'h1f;
	localparam logic [BYTE_W-1:0] LATCH_MASK = 8'h7f;
	localparam logic [BYTE_W-1:0] IRQ_KEEP_MASK = 8'h01;

	// reset values
	localparam logic [BYTE_W-1:0] RST_ZERO = 8'h00;
	localparam logic [BYTE_W-1:0] RST_STATUS_POR = 8'h18;
	localparam logic [BYTE_W-1:0] RST_IRQ = 8'h00;
	localparam logic [PC_W-1:0] RST_PC = 15'h0000;
endpackage : crbm_pkg

/* verilog/crbm_ptr_pair.sv */
module crbm_ptr_pair (
	input wire logic sys_clk, // core clock
	input wire logic rst_n, // power-on / brown-out reset
	input wire logic warm_reset, // any other reset, one-cycle pulse
	input wire logic wr_low, // write strobe, low byte
	input wire logic wr_high, // write strobe, high byte
	input wire logic [crbm_pkg::BYTE_W-1:0] wdata, // write data
	output logic [crbm_pkg::BYTE_W-1:0] low_reg, // low pointer byte
	output logic [crbm_pkg::BYTE_W-1:0] high_reg // high pointer byte
);
	import crbm_pkg::*;

	// low byte survives warm resets, so a pointer set up before a watchdog trip keeps its low byte; the high byte clears
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_reg <= RST_ZERO;
		end else if (wr_low) begin
			low_reg <= wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			high_reg <= RST_ZERO;
		end else if (warm_reset) begin
			high_reg <= RST_ZERO;
		end else if (wr_high) begin
			high_reg <= wdata;
		end
	end
endmodule : crbm_ptr_pair

/* verilog/crbm_pc_unit.sv */
module crbm_pc_unit (
	input wire logic sys_clk, // core clock
	input wire logic rst_n, // power-on / brown-out reset
	input wire logic warm_reset, // any other reset, one-cycle pulse
	input wire logic wr_pc_low, // software write of the low byte
	input wire logic wr_latch, // software write of the high latch
	input wire logic [crbm_pkg::BYTE_W-1:0] wdata, // write data
	input wire logic pc_step, // core advances the counter by one
	input wire logic pc_jump, // core loads a full target
	input wire logic [crbm_pkg::PC_W-1:0] pc_target, // jump target
	output logic [crbm_pkg::PC_W-1:0] pc_reg, // program counter
	output logic [crbm_pkg::BYTE_W-1:0] latch_reg // high latch, bit 7 always zero
);
	import crbm_pkg::*;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_reg <= RST_ZERO;
		end else if (warm_reset) begin
			latch_reg <= RST_ZERO;
		end else if (wr_latch) begin
			latch_reg <= wdata & LATCH_MASK;
		end
	end

	// a software write beats the core's own step or jump in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_reg <= RST_PC;
		end else if (warm_reset) begin
			pc_reg <= RST_PC;
		end else if (wr_pc_low) begin
			pc_reg <= {latch_reg[PC_W-BYTE_W-1:0], wdata};
		end else if (pc_jump) begin
			pc_reg <= pc_target;
		end else if (pc_step) begin
			pc_reg <= pc_reg + 15'h0001;
		end
	end
endmodule : crbm_pc_unit

/* verilog/crbm_core_regs.sv */
module crbm_core_regs (
	input wire logic sys_clk, // core clock, 250 MHz
	input wire logic rst_n, // power-on / brown-out reset, async
	input wire logic warm_reset, // other reset, one-cycle pulse
	input wire logic cause_load, // load timeout/powerdown from cause
	input wire logic cause_timeout, // timeout value to load
	input wire logic cause_powerdown, // powerdown value to load
	input wire logic [crbm_pkg::ADDR_W-1:0] core_addr, // data-memory address
	input wire logic core_rd, // read request
	input wire logic core_wr, // write request
	input wire logic [crbm_pkg::BYTE_W-1:0] core_wdata, // write data
	input wire logic [2:0] alu_flag_we, // per-flag update: zero, digit carry, carry
	input wire logic [2:0] alu_flags, // new zero, dc, carry
	input wire logic [2:0] irq_event, // hardware sets of the low irq flags
	input wire logic pc_step, // advance program counter
	input wire logic pc_jump, // load program counter
	input wire logic [crbm_pkg::PC_W-1:0] pc_target, // jump target
	input wire logic [crbm_pkg::BYTE_W-1:0] ind_mem_rdata, // memory data for window read
	output logic [crbm_pkg::BYTE_W-1:0] core_rdata_reg, // read data
	output logic core_rvalid_reg, // read data valid pulse
	output logic core_hit_reg, // last access fell in the core group
	output logic [crbm_pkg::PTR_W-1:0] ind_mem_addr_reg, // window target address
	output logic ind_mem_rd_reg, // window read pulse
	output logic ind_mem_wr_reg, // window write pulse
	output logic [crbm_pkg::BYTE_W-1:0] ind_mem_wdata_reg, // window write data
	output logic [crbm_pkg::BANK_W-1:0] bank_sel_reg, // bank for direct addressing
	output logic [crbm_pkg::BYTE_W-1:0] working_reg, // working accumulator
	output logic [crbm_pkg::PC_W-1:0] pc_out_reg, // program counter
	output logic [crbm_pkg::BYTE_W-1:0] status_reg, // status flags
	output logic [crbm_pkg::BYTE_W-1:0] irq_ctrl_reg // interrupt control
);
	import crbm_pkg::*;

	logic [SLOT_W-1:0] slot;
	logic in_group;
	logic sel_win0, sel_win1, sel_pc_low, sel_status, sel_p0l, sel_p0h;
	logic sel_p1l, sel_p1h, sel_bank, sel_work, sel_latch, sel_irq;
	logic [BYTE_W-1:0] p0_low, p0_high, p1_low, p1_high, latch_val;
	logic [PC_W-1:0] pc_val;
	logic [BYTE_W-1:0] rdata_next;
	logic ind_pend_reg;
	logic win_rd, win_wr;
	logic [PTR_W-1:0] win_addr;

	// bank bits are ignored so every bank sees the same group
	assign slot = core_addr[SLOT_W-1:0];
	assign in_group = (slot <= OFF_GROUP_LAST[SLOT_W-1:0]);
	assign sel_win0 = (slot == OFF_WINDOW0[SLOT_W-1:0]);
	assign sel_win1 = (slot == OFF_WINDOW1[SLOT_W-1:0]);
	assign sel_pc_low = (slot == OFF_PC_LOW[SLOT_W-1:0]);
	assign sel_status = (slot == OFF_STATUS[SLOT_W-1:0]);
	assign sel_p0l = (slot == OFF_PTR0_LOW[SLOT_W-1:0]);
	assign sel_p0h = (slot == OFF_PTR0_HIGH[SLOT_W-1:0]);
	assign sel_p1l = (slot == OFF_PTR1_LOW[SLOT_W-1:0]);
	assign sel_p1h = (slot == OFF_PTR1_HIGH[SLOT_W-1:0]);
	assign sel_bank = (slot == OFF_BANK_SEL[SLOT_W-1:0]);
	assign sel_work = (slot == OFF_WORKING[SLOT_W-1:0]);
	assign sel_latch = (slot == OFF_PC_LATCH[SLOT_W-1:0]);
	assign sel_irq = (slot == OFF_IRQ_CTRL[SLOT_W-1:0]);

	// windows hold nothing: they just steer an access through a pointer pair
	assign win_rd = core_rd && (sel_win0 || sel_win1);
	assign win_wr = core_wr && (sel_win0 || sel_win1);
	assign win_addr = sel_win1 ? {p1_high, p1_low} : {p0_high, p0_low};

	crbm_ptr_pair u_ptr0 (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.warm_reset(warm_reset),
		.wr_low(core_wr && sel_p0l),
		.wr_high(core_wr && sel_p0h),
		.wdata(core_wdata),
		.low_reg(p0_low),
		.high_reg(p0_high)
	);

	crbm_ptr_pair u_ptr1 (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.warm_reset(warm_reset),
		.wr_low(core_wr && sel_p1l),
		.wr_high(core_wr && sel_p1h),
		.wdata(core_wdata),
		.low_reg(p1_low),
		.high_reg(p1_high)
	);

	crbm_pc_unit u_pc (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.warm_reset(warm_reset),
		.wr_pc_low(core_wr && sel_pc_low),
		.wr_latch(core_wr && sel_latch),
		.wdata(core_wdata),
		.pc_step(pc_step),
		.pc_jump(pc_jump),
		.pc_target(pc_target),
		.pc_reg(pc_val),
		.latch_reg(latch_val)
	);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_out_reg <= RST_PC;
		end else begin
			pc_out_reg <= pc_val;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_sel_reg <= RST_ZERO[BANK_W-1:0];
		end else if (warm_reset) begin
			bank_sel_reg <= RST_ZERO[BANK_W-1:0];
		end else if (core_wr && sel_bank) begin
			bank_sel_reg <= core_wdata[BANK_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			working_reg <= RST_ZERO;
		end else if (core_wr && sel_work) begin
			working_reg <= core_wdata;
		end
	end

	// alu flag updates win over a software write of the same bit;
	// timeout and powerdown are never software-writable
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= RST_STATUS_POR;
		end else begin
			if (warm_reset || cause_load) begin
				status_reg[ST_TIMEOUT] <= cause_timeout;
				status_reg[ST_POWERDOWN] <= cause_powerdown;
			end
			if (alu_flag_we[2]) begin
				status_reg[ST_ZERO] <= alu_flags[2];
			end else if (core_wr && sel_status && !warm_reset) begin
				status_reg[ST_ZERO] <= core_wdata[ST_ZERO];
			end
			if (alu_flag_we[1]) begin
				status_reg[ST_DIGIT_CARRY] <= alu_flags[1];
			end else if (core_wr && sel_status && !warm_reset) begin
				status_reg[ST_DIGIT_CARRY] <= core_wdata[ST_DIGIT_CARRY];
			end
			if (alu_flag_we[0]) begin
				status_reg[ST_CARRY] <= alu_flags[0];
			end else if (core_wr && sel_status && !warm_reset) begin
				status_reg[ST_CARRY] <= core_wdata[ST_CARRY];
			end
			status_reg[BYTE_W-1:ST_TIMEOUT+1] <= 3'h0;
		end
	end

	// low three flags are set by hardware; a set in the clearing cycle wins
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_ctrl_reg <= RST_IRQ;
		end else if (warm_reset) begin
			irq_ctrl_reg <= (irq_ctrl_reg & IRQ_KEEP_MASK) | {5'h00, irq_event};
		end else if (core_wr && sel_irq) begin
			irq_ctrl_reg <= core_wdata | {5'h00, irq_event};
		end else begin
			irq_ctrl_reg <= irq_ctrl_reg | {5'h00, irq_event};
		end
	end

	always_comb begin
		rdata_next = RST_ZERO;
		if (!in_group) begin
			rdata_next = RST_ZERO;
		end else if (sel_pc_low) begin
			rdata_next = pc_val[BYTE_W-1:0];
		end else if (sel_status) begin
			rdata_next = status_reg & STATUS_MASK;
		end else if (sel_p0l) begin
			rdata_next = p0_low;
		end else if (sel_p0h) begin
			rdata_next = p0_high;
		end else if (sel_p1l) begin
			rdata_next = p1_low;
		end else if (sel_p1h) begin
			rdata_next = p1_high;
		end else if (sel_bank) begin
			rdata_next = {3'h0, bank_sel_reg};
		end else if (sel_work) begin
			rdata_next = working_reg;
		end else if (sel_latch) begin
			rdata_next = latch_val & LATCH_MASK;
		end else if (sel_irq) begin
			rdata_next = irq_ctrl_reg;
		end else begin
			rdata_next = RST_ZERO;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ind_mem_addr_reg <= {PTR_W{1'b0}};
			ind_mem_rd_reg <= 1'b0;
			ind_mem_wr_reg <= 1'b0;
			ind_mem_wdata_reg <= RST_ZERO;
		end else begin
			ind_mem_rd_reg <= win_rd;
			ind_mem_wr_reg <= win_wr;
			if (win_rd || win_wr) begin
				ind_mem_addr_reg <= win_addr;
				ind_mem_wdata_reg <= core_wdata;
			end
		end
	end

	// a window read answers one cycle later than a plain register read
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ind_pend_reg <= 1'b0;
			core_rdata_reg <= RST_ZERO;
			core_rvalid_reg <= 1'b0;
			core_hit_reg <= 1'b0;
		end else begin
			ind_pend_reg <= win_rd;
			if (ind_pend_reg) begin
				core_rdata_reg <= ind_mem_rdata;
				core_rvalid_reg <= 1'b1;
			end else if (core_rd && !win_rd) begin
				core_rdata_reg <= rdata_next;
				core_rvalid_reg <= 1'b1;
			end else begin
				core_rvalid_reg <= 1'b0;
			end
			if (core_rd || core_wr) begin
				core_hit_reg <= in_group;
			end
		end
	end

	sequence win_read_req_s;
		core_rd && sel_win0 && !ind_pend_reg;
	endsequence

	sequence win_read_ans_s;
		ind_mem_rd_reg ##1 core_rvalid_reg;
	endsequence

	mirror_decode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		core_rd && !win_rd && !ind_pend_reg && sel_work |=> core_rdata_reg == $past(working_reg))
		else $error("working register not mirrored in this bank");

	unimpl_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		core_rd && !ind_pend_reg && in_group && slot > OFF_IRQ_CTRL[SLOT_W-1:0]
		|=> core_rvalid_reg && core_rdata_reg == 8'h00)
		else $error("unimplemented slot did not read zero");

	window_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		win_read_req_s |=> ind_mem_addr_reg == $past({p0_high, p0_low}) ##0 win_read_ans_s)
		else $error("window read did not go through pointer pair 0");

	latch_top_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(latch_val[7] == 1'b0) and (warm_reset |=> latch_val == 8'h00))
		else $error("high latch top bit set or not cleared");

	warm_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		warm_reset && !core_wr |=> working_reg == $past(working_reg) && p0_low == $past(p0_low))
		else $error("warm reset disturbed a cold-only register");

	warm_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		warm_reset |=> p0_high == 8'h00 && p1_high == 8'h00 && bank_sel_reg == 5'h00
		&& pc_val == 15'h0000)
		else $error("warm reset left a cleared register set");

	status_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		warm_reset |=> status_reg[ST_TIMEOUT] == $past(cause_timeout)
		&& status_reg[ST_POWERDOWN] == $past(cause_powerdown))
		else $error("status cause flags not loaded on warm reset");

	bank_width_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		core_wr && sel_bank && !warm_reset |=> bank_sel_reg == $past(core_wdata[BANK_W-1:0]))
		else $error("bank selector write lost");

	pc_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		pc_step && !pc_jump && !warm_reset && !(core_wr && sel_pc_low)
		|=> pc_val == $past(pc_val) + 15'h0001)
		else $error("program counter did not advance by one");

	pc_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		core_wr && sel_pc_low && !warm_reset
		|=> pc_val == {$past(latch_val[6:0]), $past(core_wdata)} ##1 pc_out_reg == $past(pc_val))
		else $error("counter low write did not take upper bits from latch");
endmodule : crbm_core_regs

/* testbench/crbm_mem_model.sv */
module crbm_mem_model (
	input wire logic sys_clk, // core clock
	input wire logic [crbm_pkg::PTR_W-1:0] mem_addr, // window target address
	input wire logic mem_rd, // window read pulse
	output logic [crbm_pkg::BYTE_W-1:0] mem_rdata // read data
);
	timeunit 1ns;
	timeprecision 1ps;
	import crbm_pkg::*;
	logic [BYTE_W-1:0] last_reg = 8'h00;
	// data is a hash of the address so the bench can predict it; off-cycle the
	// bus shows the inverse of the last value, so a late sample never matches
	assign mem_rdata = mem_rd ? (mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3c) : ~last_reg;
	always_ff @(posedge sys_clk) begin
		if (mem_rd) begin
			last_reg <= mem_rdata;
		end
	end
endmodule : crbm_mem_model

/* testbench/tb_core_register_bank_mirror.sv */
module tb_core_register_bank_mirror;
	timeunit 1ns;
	timeprecision 1ps;
	import crbm_pkg::*;
	`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
		$display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic warm_reset = 1'b0, cause_load = 1'b0, cause_timeout = 1'b0, cause_powerdown = 1'b0;
	logic core_rd = 1'b0, core_wr = 1'b0, pc_step = 1'b0, pc_jump = 1'b0;
	logic [ADDR_W-1:0] core_addr = '0;
	logic [BYTE_W-1:0] core_wdata = '0, ind_mem_rdata, core_rdata_reg, ind_mem_wdata_reg;
	logic [2:0] alu_flag_we = '0, alu_flags = '0, irq_event = '0;
	logic [PC_W-1:0] pc_target = '0, pc_out_reg;
	logic core_rvalid_reg, core_hit_reg, ind_mem_rd_reg, ind_mem_wr_reg;
	logic [PTR_W-1:0] ind_mem_addr_reg;
	logic [BANK_W-1:0] bank_sel_reg;
	logic [BYTE_W-1:0] working_reg, status_reg, irq_ctrl_reg;
	int err_total = 0;
	int check_count = 0;
	localparam logic [7:0] POR_EXP [2:10] = '{8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00};
	localparam logic [7:0] FULL_EXP [2:10] = '{8'hff, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff,
		8'h1f, 8'hff, 8'h7f};
	localparam logic [7:0] WARM_EXP [2:10] = '{8'h00, 8'h0f, 8'hff, 8'h00, 8'hff, 8'h00,
		8'h00, 8'hff, 8'h00};

	crbm_core_regs crbm_core_regs_i (.sys_clk, .rst_n, .warm_reset, .cause_load,
		.cause_timeout, .cause_powerdown, .core_addr, .core_rd, .core_wr, .core_wdata,
		.alu_flag_we, .alu_flags, .irq_event, .pc_step, .pc_jump, .pc_target,
		.ind_mem_rdata, .core_rdata_reg, .core_rvalid_reg, .core_hit_reg,
		.ind_mem_addr_reg, .ind_mem_rd_reg, .ind_mem_wr_reg, .ind_mem_wdata_reg,
		.bank_sel_reg, .working_reg, .pc_out_reg, .status_reg, .irq_ctrl_reg);
	crbm_mem_model crbm_mem_model_i (.sys_clk(sys_clk), .mem_addr(ind_mem_addr_reg),
		.mem_rd(ind_mem_rd_reg), .mem_rdata(ind_mem_rdata));

	initial begin
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
		@(posedge sys_clk);
		core_wr <= 1'b1;
		core_addr <= a;
		core_wdata <= d;
		@(posedge sys_clk);
		core_wr <= 1'b0;
	endtask : wr

	// waits for the answer under a bound; window reads answer one cycle later
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] e);
		int n;
		@(posedge sys_clk);
		core_rd <= 1'b1;
		core_addr <= a;
		@(posedge sys_clk);
		core_rd <= 1'b0;
		#1;
		n = 0;
		while (core_rvalid_reg !== 1'b1 && n < 4) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		`CHK(core_rvalid_reg, 1'b1)
		`CHK(core_rdata_reg, e)
	endtask : rd

	task automatic rd_slots(input logic [ADDR_W-1:0] base, input logic [7:0] e [2:10]);
		for (int s = 2; s <= 10; s++) begin
			rd(base | ADDR_W'(s), e[s]);
		end
	endtask : rd_slots

	task automatic t_por_values();
		rd_slots(12'h000, POR_EXP);
		`CHK(pc_out_reg, RST_PC)
		$display("test por_values done");
	endtask : t_por_values

	task automatic t_mirror();
		for (int s = 2; s <= 10; s++) begin
			wr(12'hf80 | ADDR_W'(s), 8'hff);
		end
		rd_slots(12'h000, FULL_EXP);
		rd_slots(12'h380, FULL_EXP);
		`CHK(bank_sel_reg, 5'h1f)
		$display("test mirror done");
	endtask : t_mirror

	task automatic t_unimpl();
		wr(12'h10c, 8'hff);
		rd(12'h00c, 8'h00);
		rd(12'h09f, 8'h00);
		`CHK(core_hit_reg, 1'b1)
		rd(12'h0a0, 8'h00);
		`CHK(core_hit_reg, 1'b0)
		$display("test unimpl done");
	endtask : t_unimpl

	task automatic t_warm();
		@(posedge sys_clk);
		warm_reset <= 1'b1;
		cause_powerdown <= 1'b1;
		@(posedge sys_clk);
		warm_reset <= 1'b0;
		// the counter clears at the reset edge and its output copy follows one edge later
		@(posedge sys_clk);
		#1;
		`CHK(pc_out_reg, RST_PC)
		`CHK(working_reg, 8'hff)
		rd_slots(12'h000, WARM_EXP);
		@(posedge sys_clk);
		alu_flag_we <= 3'h7;
		alu_flags <= 3'h5;
		@(posedge sys_clk);
		alu_flag_we <= 3'h0;
		rd(12'h003, 8'h0d);
		$display("test warm_reset done");
	endtask : t_warm

	task automatic t_pc();
		wr(12'hf8a, 8'h55);
		wr(12'h082, 8'ha3);
		@(posedge sys_clk);
		#1;
		`CHK(pc_out_reg, 15'h55a3)
		@(posedge sys_clk);
		pc_step <= 1'b1;
		@(posedge sys_clk);
		pc_step <= 1'b0;
		@(posedge sys_clk);
		#1;
		`CHK(pc_out_reg, 15'h55a4)
		rd(12'h002, 8'ha4);
		@(posedge sys_clk);
		pc_jump <= 1'b1;
		pc_target <= 15'h7f00;
		@(posedge sys_clk);
		pc_jump <= 1'b0;
		@(posedge sys_clk);
		#1;
		`CHK(pc_out_reg, 15'h7f00)
		$display("test pc_load done");
	endtask : t_pc

	task automatic t_window();
		wr(12'h284, 8'h34);
		wr(12'h285, 8'h12);
		rd(12'h000, 8'h34 ^ 8'h12 ^ 8'h3c);
		`CHK(ind_mem_addr_reg, 16'h1234)
		wr(12'h086, 8'h78);
		wr(12'h087, 8'h56);
		rd(12'h101, 8'h78 ^ 8'h56 ^ 8'h3c);
		wr(12'h781, 8'h9a);
		// the write pulse stands only in the cycle after the taking edge
		#1;
		`CHK(ind_mem_wr_reg, 1'b1)
		`CHK(ind_mem_addr_reg, 16'h5678)
		`CHK(ind_mem_wdata_reg, 8'h9a)
		$display("test window done");
	endtask : t_window

	// a hardware set must survive a software clear in the same cycle
	task automatic t_irq_cause();
		wr(12'hf8b, 8'hff);
		rd(12'h08b, 8'hff);
		@(posedge sys_clk);
		core_wr <= 1'b1;
		core_addr <= 12'h00b;
		core_wdata <= 8'h00;
		irq_event <= 3'h4;
		@(posedge sys_clk);
		core_wr <= 1'b0;
		irq_event <= 3'h0;
		#1;
		`CHK(irq_ctrl_reg, 8'h04)
		@(posedge sys_clk);
		cause_load <= 1'b1;
		cause_timeout <= 1'b1;
		cause_powerdown <= 1'b0;
		@(posedge sys_clk);
		cause_load <= 1'b0;
		#1;
		`CHK(status_reg, 8'h15)
		$display("test irq_cause done");
	endtask : t_irq_cause

	task automatic t_cold_again();
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK(status_reg, RST_STATUS_POR)
		@(posedge sys_clk);
		rst_n <= 1'b1;
		rd_slots(12'h000, POR_EXP);
		$display("test cold_again done");
	endtask : t_cold_again

	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_por_values();
		t_mirror();
		t_unimpl();
		t_warm();
		t_pc();
		t_window();
		t_irq_cause();
		t_cold_again();
		finish_test();
	end

	// the whole sequence needs well under 1000 cycles
	initial begin
		#20000;
		err_total++;
		finish_test();
	end
endmodule : tb_core_register_bank_mirror
